/* File: cpf_pkg.sv */
// Package of constants and types for the cache prefetch unit
package cpf_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CPF_OFS_CTRL = 8'h00;
    localparam logic [7:0] CPF_OFS_STATUS = 8'h04;
    localparam logic [7:0] CPF_OFS_COUNT = 8'h08;
    localparam logic [7:0] CPF_OFS_IDENT = 8'h0c;

    // Control register fields
    localparam int CPF_CTRL_ENABLE_BIT = 0;
    localparam int CPF_CTRL_REPORT_ERR_BIT = 1;
    localparam int CPF_CTRL_CLEAN_INVAL_BIT = 2;
    localparam logic [2:0] CPF_CTRL_RESET = 3'h1;

    // Status register fields
    localparam int CPF_STAT_BUSY_BIT = 0;
    localparam int CPF_STAT_OUTCOME_LSB = 1;
    localparam int CPF_STAT_ERR_BIT = 4;
    localparam int CPF_STAT_HINT_LSB = 8;

    // Identity value is arbitrary
    localparam logic [31:0] CPF_IDENT_VALUE = 32'h0000_c0de;

    // Instruction fields
    localparam int CPF_OFFSET_LSB = 0;
    localparam int CPF_OFFSET_W = 16;
    localparam int CPF_HINT_LSB = 16;
    localparam int CPF_HINT_W = 5;

    // Usage-intent codes
    localparam logic [4:0] CPF_HINT_LOAD = 5'h00;
    localparam logic [4:0] CPF_HINT_STORE = 5'h01;
    localparam logic [4:0] CPF_HINT_LOAD_STREAMED = 5'h04;
    localparam logic [4:0] CPF_HINT_STORE_STREAMED = 5'h05;
    localparam logic [4:0] CPF_HINT_LOAD_RETAINED = 5'h06;
    localparam logic [4:0] CPF_HINT_STORE_RETAINED = 5'h07;
    localparam logic [4:0] CPF_HINT_FLUSH_DROP = 5'h19;
    localparam logic [4:0] CPF_HINT_ZERO_FILL = 5'h1e;

    // Access attributes
    localparam logic [2:0] CPF_CCA_UNCACHED = 3'h2;
    localparam logic [31:0] CPF_UNCACHED_SEG_BASE = 32'ha000_0000;
    localparam logic [31:0] CPF_UNCACHED_SEG_MASK = 32'he000_0000;

    // Outcome codes shown in status
    localparam logic [2:0] CPF_OUT_NONE = 3'h0;
    localparam logic [2:0] CPF_OUT_NOP = 3'h1;
    localparam logic [2:0] CPF_OUT_FAULT = 3'h2;
    localparam logic [2:0] CPF_OUT_UNCACHED = 3'h3;
    localparam logic [2:0] CPF_OUT_ACTED = 3'h4;
    localparam logic [2:0] CPF_OUT_ERROR = 3'h5;

    typedef enum logic [2:0] {
        CPF_CMD_FETCH_LOAD = 3'b000,
        CPF_CMD_FETCH_STORE = 3'b001,
        CPF_CMD_WRITEBACK = 3'b010,
        CPF_CMD_INVALIDATE = 3'b011,
        CPF_CMD_ZERO_FILL = 3'b100
    } cpf_cmd_e;

    typedef enum logic [2:0] {
        CPF_ST_IDLE = 3'b000,
        CPF_ST_XLATE = 3'b001,
        CPF_ST_PROBE = 3'b010,
        CPF_ST_WB = 3'b011,
        CPF_ST_INVAL = 3'b100,
        CPF_ST_FETCH = 3'b101,
        CPF_ST_ZFILL = 3'b110,
        CPF_ST_DONE = 3'b111
    } cpf_state_e;

endpackage

/* File: cpf_unit.sv */
// Cache prefetch unit: address forming, intent decode and cache action sequencing
//
// Operation
// - Address is base plus sign-extended displacement
// - Any action allowed if invisible, except zero-fill
// - Never raise address faults; move no data
// - Faulted prefetch may still do invisible writeback
// - Error reporting on prefetch is implementation choice
// - Uncached address: no memory op, no change
// - Memory ops use the address's own attribute
// - Cached address fetches block holding the address
// - Coherent attribute gives coherent memory transaction
// - Prefetch obeys memory barrier ordering and completion
// - Code 0 fetches for load, 1 for store
// - Codes 2-3 and 8-20 stay reserved
// - Codes 4, 5 streamed, never displace retained
// - Codes 6, 7 retained, streamed never displace
// - Codes 21-24, 26-29, 31 implementation defined
// - Code 25 writes back dirty, then invalidates
// - Flush-drop skips locked; clean line optional invalidate
// - Zero-fill hit takes no action
// - Zero-fill miss: victim, writeback, zero, valid dirty
// - Locked lines are never touched by prefetch
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps

module cpf_unit #(
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [31:0] issue_instr,
    input wire logic [ADDR_W-1:0] issue_base,
    output logic prefetch_busy,
    output logic prefetch_done,
    output logic prefetch_err_exc,
    output logic xlate_req,
    output logic [ADDR_W-1:0] xlate_vaddr,
    input wire logic xlate_ack,
    input wire logic [ADDR_W-1:0] xlate_paddr,
    input wire logic [2:0] xlate_cca,
    input wire logic xlate_fault,
    output logic probe_req,
    output logic [ADDR_W-1:0] probe_paddr,
    input wire logic probe_ack,
    input wire logic probe_hit,
    input wire logic probe_dirty,
    input wire logic probe_locked,
    input wire logic probe_victim_valid,
    input wire logic probe_victim_dirty,
    output logic cmd_valid,
    output logic [2:0] cmd_op,
    output logic [ADDR_W-1:0] cmd_paddr,
    output logic [2:0] cmd_cca,
    output logic cmd_streamed,
    output logic cmd_retained,
    output logic cmd_victim,
    input wire logic cmd_done,
    input wire logic cmd_err,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    cpf_pkg::cpf_state_e state;
    cpf_pkg::cpf_state_e next_state;
    logic [ADDR_W-1:0] vaddr;
    logic [ADDR_W-1:0] next_vaddr;
    logic [ADDR_W-1:0] paddr;
    logic [ADDR_W-1:0] next_paddr;
    logic [2:0] cca;
    logic [2:0] next_cca;
    logic [4:0] hint;
    logic [4:0] next_hint;
    logic victim_sel;
    logic next_victim_sel;
    logic err_hit;
    logic next_err_hit;
    logic [2:0] outcome;
    logic [2:0] next_outcome;

    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic err_seen;
    logic next_err_seen;
    logic [31:0] done_count;
    logic [31:0] next_done_count;
    logic [31:0] next_rdata;

    logic [ADDR_W-1:0] disp_ext;
    logic [4:0] issue_hint;
    logic hint_fetch;
    logic hint_store;
    logic hint_streamed;
    logic hint_retained;
    logic hint_defined;
    logic addr_uncached;
    logic wr_ctrl;
    logic wr_status;

    // Intent decode
    assign issue_hint = issue_instr[cpf_pkg::CPF_HINT_LSB +: cpf_pkg::CPF_HINT_W];
    assign disp_ext = ADDR_W'($signed(issue_instr[cpf_pkg::CPF_OFFSET_LSB +:
        cpf_pkg::CPF_OFFSET_W]));

    always_comb begin
        hint_fetch = 1'b0;
        hint_store = 1'b0;
        hint_streamed = 1'b0;
        hint_retained = 1'b0;
        hint_defined = 1'b1;
        case (hint)
            cpf_pkg::CPF_HINT_LOAD: begin
                hint_fetch = 1'b1;
            end
            cpf_pkg::CPF_HINT_STORE: begin
                hint_fetch = 1'b1;
                hint_store = 1'b1;
            end
            cpf_pkg::CPF_HINT_LOAD_STREAMED: begin
                hint_fetch = 1'b1;
                hint_streamed = 1'b1;
            end
            cpf_pkg::CPF_HINT_STORE_STREAMED: begin
                hint_fetch = 1'b1;
                hint_store = 1'b1;
                hint_streamed = 1'b1;
            end
            cpf_pkg::CPF_HINT_LOAD_RETAINED: begin
                hint_fetch = 1'b1;
                hint_retained = 1'b1;
            end
            cpf_pkg::CPF_HINT_STORE_RETAINED: begin
                hint_fetch = 1'b1;
                hint_store = 1'b1;
                hint_retained = 1'b1;
            end
            cpf_pkg::CPF_HINT_FLUSH_DROP: begin
                hint_defined = 1'b1;
            end
            cpf_pkg::CPF_HINT_ZERO_FILL: begin
                hint_defined = 1'b1;
            end
            default: begin
                // Reserved and unassigned codes are held back from any meaning
                hint_defined = 1'b0;
            end
        endcase
    end

    // Uncached by segment or by the translated attribute
    assign addr_uncached = ((vaddr & cpf_pkg::CPF_UNCACHED_SEG_MASK) ==
        cpf_pkg::CPF_UNCACHED_SEG_BASE) || (xlate_cca == cpf_pkg::CPF_CCA_UNCACHED);

    // Handshake outputs
    assign issue_ready = (state == cpf_pkg::CPF_ST_IDLE);
    // Barrier waits on busy, so refills and writebacks finish before it retires
    assign prefetch_busy = (state != cpf_pkg::CPF_ST_IDLE);
    assign xlate_req = (state == cpf_pkg::CPF_ST_XLATE);
    assign probe_req = (state == cpf_pkg::CPF_ST_PROBE);
    assign cmd_valid = (state == cpf_pkg::CPF_ST_WB) || (state == cpf_pkg::CPF_ST_INVAL) ||
        (state == cpf_pkg::CPF_ST_FETCH) || (state == cpf_pkg::CPF_ST_ZFILL);
    assign xlate_vaddr = vaddr;
    assign probe_paddr = paddr;
    assign cmd_paddr = paddr;
    assign cmd_cca = cca;
    assign cmd_streamed = hint_streamed;
    assign cmd_retained = hint_retained;
    assign cmd_victim = victim_sel;

    always_comb begin
        case (state)
            cpf_pkg::CPF_ST_WB: cmd_op = cpf_pkg::CPF_CMD_WRITEBACK;
            cpf_pkg::CPF_ST_INVAL: cmd_op = cpf_pkg::CPF_CMD_INVALIDATE;
            cpf_pkg::CPF_ST_ZFILL: cmd_op = cpf_pkg::CPF_CMD_ZERO_FILL;
            default: cmd_op = hint_store ? cpf_pkg::CPF_CMD_FETCH_STORE :
                cpf_pkg::CPF_CMD_FETCH_LOAD;
        endcase
    end

    // Sequencer
    always_comb begin
        next_state = state;
        next_vaddr = vaddr;
        next_paddr = paddr;
        next_cca = cca;
        next_hint = hint;
        next_victim_sel = victim_sel;
        next_err_hit = err_hit;
        next_outcome = outcome;
        case (state)
            cpf_pkg::CPF_ST_IDLE: begin
                if (issue_valid) begin
                    next_vaddr = issue_base + disp_ext;
                    next_hint = issue_hint;
                    next_victim_sel = 1'b0;
                    next_err_hit = 1'b0;
                    next_state = cpf_pkg::CPF_ST_XLATE;
                end
            end
            cpf_pkg::CPF_ST_XLATE: begin
                if (xlate_ack) begin
                    next_paddr = xlate_paddr;
                    next_cca = xlate_cca;
                    if (xlate_fault) begin
                        // Fault is swallowed; the optional writeback is not taken
                        next_outcome = cpf_pkg::CPF_OUT_FAULT;
                        next_state = cpf_pkg::CPF_ST_DONE;
                    end else if (!ctrl[cpf_pkg::CPF_CTRL_ENABLE_BIT] || !hint_defined) begin
                        next_outcome = cpf_pkg::CPF_OUT_NOP;
                        next_state = cpf_pkg::CPF_ST_DONE;
                    end else if (addr_uncached) begin
                        next_outcome = cpf_pkg::CPF_OUT_UNCACHED;
                        next_state = cpf_pkg::CPF_ST_DONE;
                    end else begin
                        next_state = cpf_pkg::CPF_ST_PROBE;
                    end
                end
            end
            cpf_pkg::CPF_ST_PROBE: begin
                if (probe_ack) begin
                    next_outcome = cpf_pkg::CPF_OUT_ACTED;
                    next_state = cpf_pkg::CPF_ST_DONE;
                    if (probe_hit && probe_locked) begin
                        next_outcome = cpf_pkg::CPF_OUT_NOP;
                    end else if (hint_fetch) begin
                        if (!probe_hit) begin
                            next_state = cpf_pkg::CPF_ST_FETCH;
                        end
                    end else if (hint == cpf_pkg::CPF_HINT_FLUSH_DROP) begin
                        if (probe_hit && probe_dirty) begin
                            next_state = cpf_pkg::CPF_ST_WB;
                        end else if (probe_hit &&
                                ctrl[cpf_pkg::CPF_CTRL_CLEAN_INVAL_BIT]) begin
                            next_state = cpf_pkg::CPF_ST_INVAL;
                        end
                    end else begin
                        if (probe_hit) begin
                            next_outcome = cpf_pkg::CPF_OUT_NOP;
                        end else if (probe_victim_valid && probe_victim_dirty) begin
                            next_victim_sel = 1'b1;
                            next_state = cpf_pkg::CPF_ST_WB;
                        end else begin
                            next_state = cpf_pkg::CPF_ST_ZFILL;
                        end
                    end
                end
            end
            cpf_pkg::CPF_ST_WB: begin
                if (cmd_done) begin
                    if (cmd_err) begin
                        // Failed writeback leaves the line as it was
                        next_err_hit = 1'b1;
                        next_outcome = cpf_pkg::CPF_OUT_ERROR;
                        next_state = cpf_pkg::CPF_ST_DONE;
                    end else if (victim_sel) begin
                        next_state = cpf_pkg::CPF_ST_ZFILL;
                    end else begin
                        next_state = cpf_pkg::CPF_ST_INVAL;
                    end
                end
            end
            cpf_pkg::CPF_ST_INVAL, cpf_pkg::CPF_ST_FETCH, cpf_pkg::CPF_ST_ZFILL: begin
                if (cmd_done) begin
                    if (cmd_err) begin
                        next_err_hit = 1'b1;
                        next_outcome = cpf_pkg::CPF_OUT_ERROR;
                    end
                    next_state = cpf_pkg::CPF_ST_DONE;
                end
            end
            cpf_pkg::CPF_ST_DONE: begin
                next_state = cpf_pkg::CPF_ST_IDLE;
            end
            default: begin
                next_state = cpf_pkg::CPF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= cpf_pkg::CPF_ST_IDLE;
            vaddr <= '0;
            paddr <= '0;
            cca <= 3'h0;
            hint <= 5'h00;
            victim_sel <= 1'b0;
            err_hit <= 1'b0;
            outcome <= cpf_pkg::CPF_OUT_NONE;
        end else begin
            state <= next_state;
            vaddr <= next_vaddr;
            paddr <= next_paddr;
            cca <= next_cca;
            hint <= next_hint;
            victim_sel <= next_victim_sel;
            err_hit <= next_err_hit;
            outcome <= next_outcome;
        end
    end

    // Completion pulses come straight from the done state
    assign prefetch_done = (state == cpf_pkg::CPF_ST_DONE);
    assign prefetch_err_exc = prefetch_done && err_hit &&
        ctrl[cpf_pkg::CPF_CTRL_REPORT_ERR_BIT];

    // Register port
    assign wr_ctrl = reg_wr && (reg_addr == cpf_pkg::CPF_OFS_CTRL);
    assign wr_status = reg_wr && (reg_addr == cpf_pkg::CPF_OFS_STATUS);

    always_comb begin
        next_ctrl = ctrl;
        next_err_seen = err_seen;
        next_done_count = done_count;
        next_rdata = 32'h0000_0000;
        if (wr_ctrl) begin
            next_ctrl = reg_wdata[2:0];
        end
        if (wr_status && reg_wdata[cpf_pkg::CPF_STAT_ERR_BIT]) begin
            next_err_seen = 1'b0;
        end
        // Set after clear so a same-cycle error is kept
        if (prefetch_done && err_hit) begin
            next_err_seen = 1'b1;
        end
        if (prefetch_done) begin
            next_done_count = done_count + 32'h0000_0001;
        end
        if (reg_rd) begin
            case (reg_addr)
                cpf_pkg::CPF_OFS_CTRL: begin
                    next_rdata = {29'h0000_0000, ctrl};
                end
                cpf_pkg::CPF_OFS_STATUS: begin
                    next_rdata[cpf_pkg::CPF_STAT_BUSY_BIT] = prefetch_busy;
                    next_rdata[cpf_pkg::CPF_STAT_OUTCOME_LSB +: 3] = outcome;
                    next_rdata[cpf_pkg::CPF_STAT_ERR_BIT] = err_seen;
                    next_rdata[cpf_pkg::CPF_STAT_HINT_LSB +: 5] = hint;
                end
                cpf_pkg::CPF_OFS_COUNT: begin
                    next_rdata = done_count;
                end
                cpf_pkg::CPF_OFS_IDENT: begin
                    next_rdata = cpf_pkg::CPF_IDENT_VALUE;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= cpf_pkg::CPF_CTRL_RESET;
            err_seen <= 1'b0;
            done_count <= 32'h0000_0000;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            err_seen <= next_err_seen;
            done_count <= next_done_count;
            reg_rdata <= next_rdata;
        end
    end

endmodule

/* File: cpf_monitor.sv */
// Property checker bound to the prefetch unit ports
`timescale 1ns/1ps
module cpf_monitor #(
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [31:0] issue_instr,
    input wire logic [ADDR_W-1:0] issue_base,
    input wire logic prefetch_busy,
    input wire logic prefetch_done,
    input wire logic xlate_req,
    input wire logic [ADDR_W-1:0] xlate_vaddr,
    input wire logic xlate_ack,
    input wire logic [ADDR_W-1:0] xlate_paddr,
    input wire logic [2:0] xlate_cca,
    input wire logic xlate_fault,
    input wire logic probe_req,
    input wire logic probe_ack,
    input wire logic probe_hit,
    input wire logic probe_locked,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [ADDR_W-1:0] cmd_paddr,
    input wire logic [2:0] cmd_cca,
    input wire logic cmd_victim,
    input wire logic cmd_done,
    input wire logic cmd_err
);
    logic [2:0] cca_q;
    logic [ADDR_W-1:0] pa_q;
    logic nop_op;
    logic known;
    logic [31:0] disp_ext;
    assign disp_ext = {{16{issue_instr[15]}}, issue_instr[15:0]};
    assign known = issue_instr[20:16] inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07,
        5'h19, 5'h1e};
    // Attribute of the translation in flight, for the command comparison
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cca_q <= 3'h0;
            pa_q <= '0;
            nop_op <= 1'b0;
        end else begin
            if (xlate_req && xlate_ack) begin
                cca_q <= xlate_cca;
                pa_q <= xlate_paddr;
            end
            if (issue_valid && issue_ready) nop_op <= !known;
            else if (prefetch_done) nop_op <= 1'b0;
        end
    end
    default clocking dclk @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_hit_wb_ok;
        cmd_valid && cmd_done && !cmd_err && !cmd_victim && cmd_op == 3'h2;
    endsequence
    sequence s_victim_wb_ok;
        cmd_valid && cmd_done && !cmd_err && cmd_victim && cmd_op == 3'h2;
    endsequence
    chk_issue_xlate: assert property (issue_valid && issue_ready |=>
        xlate_req && prefetch_busy && !issue_ready) else $error("issue not taken");
    chk_vaddr_form: assert property (issue_valid && issue_ready |=>
        xlate_vaddr == $past(issue_base) + $past(disp_ext)) else $error("bad address");
    chk_fault_quiet: assert property (xlate_req && xlate_ack && xlate_fault |=>
        prefetch_done && !probe_req && !cmd_valid) else $error("fault not dropped");
    chk_uncached_quiet: assert property (xlate_req && xlate_ack &&
        (xlate_cca == 3'h2 || (xlate_vaddr & 32'he000_0000) == 32'ha000_0000)
        |=> prefetch_done && !probe_req && !cmd_valid) else $error("uncached acted");
    chk_cmd_attr: assert property (cmd_valid |-> cmd_cca == cca_q &&
        (cmd_victim || cmd_paddr == pa_q)) else $error("command attribute");
    chk_cmd_hold: assert property (cmd_valid && !cmd_done |=> cmd_valid &&
        $stable(cmd_op) && $stable(cmd_paddr)) else $error("command dropped");
    chk_nop_quiet: assert property (nop_op |-> !cmd_valid && !probe_req)
        else $error("undefined code acted");
    chk_locked_skip: assert property (probe_req && probe_ack && probe_hit &&
        probe_locked |=> !cmd_valid [*2]) else $error("locked line touched");
    chk_flush_order: assert property (s_hit_wb_ok |-> ##[1:2]
        (cmd_valid && cmd_op == 3'h3)) else $error("no invalidate");
    chk_zfill_order: assert property (s_victim_wb_ok |-> ##[1:2]
        (cmd_valid && cmd_op == 3'h4)) else $error("no zero fill");
    chk_err_abort: assert property (cmd_valid && cmd_done && cmd_err |=>
        !cmd_valid [*2]) else $error("step after error");
endmodule
bind cpf_unit cpf_monitor #(.ADDR_W(ADDR_W)) i_mon (.*);

/* File: cpf_mem_model.sv */
// Behavioural translator and cache answering the prefetch unit
`timescale 1ns/1ps
module cpf_mem_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [9:0] cfg,
    input wire logic [1:0] lag,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_vaddr,
    output logic xlate_ack,
    output logic [31:0] xlate_paddr,
    output logic [2:0] xlate_cca,
    output logic xlate_fault,
    input wire logic probe_req,
    output logic probe_ack,
    output logic [4:0] probe_flags,
    input wire logic cmd_valid,
    output logic cmd_done,
    output logic cmd_err
);
    logic [1:0] wait_cnt;
    logic pend;
    assign pend = (xlate_req | probe_req | cmd_valid) & !(xlate_ack | probe_ack | cmd_done);
    // Answers are valid only with their ack; otherwise inverted junk
    assign xlate_paddr = xlate_ack ? xlate_vaddr : ~xlate_vaddr;
    assign xlate_cca = xlate_ack ? cfg[8:6] : ~cfg[8:6];
    assign xlate_fault = xlate_ack ? cfg[9] : ~cfg[9];
    assign probe_flags = probe_ack ? cfg[5:1] : ~cfg[5:1];
    assign cmd_err = cmd_done ? cfg[0] : ~cfg[0];
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 2'h0;
            xlate_ack <= 1'b0;
            probe_ack <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            xlate_ack <= pend && wait_cnt == lag && xlate_req;
            probe_ack <= pend && wait_cnt == lag && probe_req;
            cmd_done <= pend && wait_cnt == lag && cmd_valid;
            wait_cnt <= (pend && wait_cnt != lag) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the prefetch unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected %s: expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_top;
    typedef struct packed {
        logic [4:0] hint;
        logic [3:0] seg;
        logic [9:0] cfg;
        logic [1:0] n;
        logic [5:0] hist;
        logic [2:0] flg;
    } cpf_row_s;
    logic sys_clk = 1'b0, arst_n = 1'b0, issue_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] issue_instr = '0, issue_base = '0, reg_wdata = '0;
    logic [7:0] reg_addr = '0;
    logic [9:0] cfg = 10'h0c0;
    logic [1:0] lag = 2'h0;
    logic issue_ready, prefetch_busy, prefetch_done, prefetch_err_exc, xlate_req, xlate_ack;
    logic xlate_fault, probe_req, probe_ack, cmd_valid, cmd_streamed, cmd_retained;
    logic cmd_victim, cmd_done, cmd_err, exc_q;
    wire probe_hit, probe_dirty, probe_locked, probe_victim_valid, probe_victim_dirty;
    logic [31:0] xlate_vaddr, xlate_paddr, probe_paddr, cmd_paddr, reg_rdata, exp_va;
    logic [2:0] xlate_cca, cmd_op, cmd_cca, flg;
    logic [5:0] hist;
    int err_count = 0, total_checks = 0, n_cmd = 0, n_ops = 0;
    // Cfg: fault, cca, hit, dirty, locked, victim valid, victim dirty, error
    cpf_row_s rows [17] = '{
        '{5'h00, 4'h1, 10'h0c0, 2'h1, 6'h00, 3'h0}, '{5'h01, 4'h1, 10'h0c0, 2'h1, 6'h01, 3'h0},
        '{5'h04, 4'h1, 10'h0c0, 2'h1, 6'h00, 3'h4}, '{5'h05, 4'h1, 10'h0c0, 2'h1, 6'h01, 3'h4},
        '{5'h06, 4'h1, 10'h0c0, 2'h1, 6'h00, 3'h2}, '{5'h07, 4'h1, 10'h0c0, 2'h1, 6'h01, 3'h2},
        '{5'h00, 4'h1, 10'h2c0, 2'h0, 6'h00, 3'h0}, '{5'h01, 4'h1, 10'h080, 2'h0, 6'h00, 3'h0},
        '{5'h00, 4'ha, 10'h0c0, 2'h0, 6'h00, 3'h0}, '{5'h19, 4'h1, 10'h0f0, 2'h2, 6'h13, 3'h0},
        '{5'h19, 4'h1, 10'h0f8, 2'h0, 6'h00, 3'h0}, '{5'h19, 4'h1, 10'h0c0, 2'h0, 6'h00, 3'h0},
        '{5'h19, 4'h1, 10'h0e0, 2'h0, 6'h00, 3'h0}, '{5'h1e, 4'h1, 10'h0e0, 2'h0, 6'h00, 3'h0},
        '{5'h1e, 4'h1, 10'h0c6, 2'h2, 6'h14, 3'h1}, '{5'h1e, 4'h1, 10'h0c4, 2'h1, 6'h04, 3'h0},
        '{5'h00, 4'h1, 10'h0e0, 2'h0, 6'h00, 3'h0}};

    cpf_unit i_dut (.*);
    cpf_mem_model i_far (.*, .probe_flags({probe_hit, probe_dirty, probe_locked,
        probe_victim_valid, probe_victim_dirty}));

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (xlate_req && xlate_ack) `CHK("xlate_vaddr", exp_va, xlate_vaddr)
        if (cmd_valid && cmd_done) begin
            `CHK("cmd_cca", cfg[8:6], cmd_cca)
            if (!cmd_victim) `CHK("cmd_paddr", exp_va, cmd_paddr)
            if (n_cmd == 0) flg = {cmd_streamed, cmd_retained, cmd_victim};
            hist = {hist[2:0], cmd_op};
            n_cmd++;
        end
        if (probe_req && probe_ack) `CHK("probe_paddr", exp_va, probe_paddr)
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        `CHK("reg_rdata", e, reg_rdata & m)
    endtask

    task automatic run_op(input logic [4:0] h, input logic [31:0] b, input logic [15:0] o,
        input int hold);
        int i;
        n_cmd = 0;
        hist = '0;
        flg = '0;
        exp_va = b + {{16{o[15]}}, o};
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        issue_instr <= {11'h0, h, o};
        issue_base <= b;
        repeat (hold + 1) @(posedge sys_clk);
        issue_valid <= 1'b0;
        for (i = 0; i < 300 && prefetch_done !== 1'b1; i++) @(posedge sys_clk);
        if (i == 300) begin
            err_count++;
            report_and_stop();
        end
        exc_q = prefetch_err_exc;
        n_ops++;
    endtask

    task automatic check_op(input logic [1:0] n, input logic [5:0] h, input logic [2:0] f);
        `CHK("cmd_count", int'(n), n_cmd)
        `CHK("cmd_ops", h, hist)
        `CHK("cmd_class", f, flg)
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK("issue_ready", 1'b1, issue_ready)
        `CHK("prefetch_busy", 1'b0, prefetch_busy)
        reg_check(cpf_pkg::CPF_OFS_CTRL, 32'h7, 32'h1);
        reg_check(cpf_pkg::CPF_OFS_IDENT, '1, cpf_pkg::CPF_IDENT_VALUE);
        reg_check(8'h10, '1, 32'h0);
        $display("reset test done");
        // Second pass with a slow far side
        for (int k = 0; k < 2; k++) begin
            lag <= (k == 0) ? 2'h0 : 2'h3;
            foreach (rows[i]) begin
                cfg <= rows[i].cfg;
                run_op(rows[i].hint, {rows[i].seg, 28'h000_0100},
                    (i % 2) ? 16'hff00 : 16'h0040, 0);
                check_op(rows[i].n, rows[i].hist, rows[i].flg);
            end
        end
        $display("table test done");
        cfg <= 10'h0c0;
        for (int h = 0; h < 32; h++) begin
            if (!(h inside {0, 1, 4, 5, 6, 7, 25, 30})) begin
                run_op(h[4:0], 32'h1000_0100, 16'h0040, 0);
                check_op(2'h0, 6'h00, 3'h0);
            end
        end
        reg_check(cpf_pkg::CPF_OFS_COUNT, '1, 32'(n_ops));
        run_op(5'h00, 32'h1000_0100, 16'h0040, 1);
        check_op(2'h1, 6'h00, 3'h0);
        $display("code and busy test done");
        reg_write(cpf_pkg::CPF_OFS_CTRL, 32'h5);
        cfg <= 10'h0e0;
        run_op(5'h19, 32'h1000_0100, 16'h0040, 0);
        check_op(2'h1, 6'h03, 3'h0);
        reg_write(cpf_pkg::CPF_OFS_CTRL, 32'h3);
        cfg <= 10'h0f1;
        run_op(5'h19, 32'h1000_0100, 16'h0040, 0);
        check_op(2'h1, 6'h02, 3'h0);
        `CHK("prefetch_err_exc", 1'b1, exc_q)
        reg_check(cpf_pkg::CPF_OFS_STATUS, 32'h1f1f, 32'h191a);
        reg_write(cpf_pkg::CPF_OFS_STATUS, 32'h10);
        reg_check(cpf_pkg::CPF_OFS_STATUS, 32'h10, 32'h0);
        reg_write(cpf_pkg::CPF_OFS_CTRL, 32'h0);
        cfg <= 10'h0c0;
        run_op(5'h00, 32'h1000_0100, 16'h0040, 0);
        check_op(2'h0, 6'h00, 3'h0);
        $display("control and error test done");
        report_and_stop();
    end
endmodule
